//--- common/boost_ctrl_defs.svh
`ifndef BOOST_CTRL_DEFS_SVH
`define BOOST_CTRL_DEFS_SVH

// Clock
`define CLK_PERIOD_NS 5
// Minimum on/off times in ns, low and high frequency bands
`define MIN_OFF_LO_NS 150
`define MIN_ON_LO_NS 150
`define MIN_OFF_HI_NS 40
`define MIN_ON_HI_NS 110
// Least times round up
`define NS_TO_CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Under-voltage timer
`define UV_TIME_MS 110
`define UV_CYCLES (`UV_TIME_MS * 1000000 / `CLK_PERIOD_NS)
// Fault recovery hold
`define RECOVERY_TIME_MS 1
`define RECOVERY_CYCLES (`RECOVERY_TIME_MS * 1000000 / `CLK_PERIOD_NS)
// Target code span, initial point at 88 percent
`define TARGET_MAX 12'h0FFF
`define TARGET_INIT_PCT 88
// Register offsets
`define REG_STATUS 4'h0
`define REG_CLEAR 4'h1
`define REG_IRQ_EN 4'h2
`define REG_CTRL 4'h3
`define REG_TARGET 4'h4
`define REG_FREQ 4'h5
// Status bit positions
`define ST_LOWER_OVERVOLT_LEVEL 0
`define ST_UPPER_OVERVOLT_LEVEL 1
`define ST_OCP 2
`define CTRL_RESET_VAL 32'h0000_0001

`endif

//--- common/boost_ctrl_pkg.sv
package boost_ctrl_pkg;
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_START = 4'b0010,
      ST_RUN = 4'b0100,
      ST_RECOVER = 4'b1000
   } mode_t;

   typedef struct packed {
      logic [5:0] sink_low;
      logic [5:0] sink_fault;
   } sink_in_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;
endpackage

//--- src/boost_ctrl.sv
`timescale 1ns/10ps
`include "boost_ctrl_defs.svh"

module boost_ctrl
   import boost_ctrl_pkg::*;
#(
   parameter int UV_CYC = `UV_CYCLES,
   parameter int REC_CYC = `RECOVERY_CYCLES,
   parameter int STEP_CYC = 64
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Pins and straps
   input wire logic enable_pin,
   input wire logic [2:0] boost_freq_select_pin,
   input wire logic [2:0] string_config_pin,
   input wire logic current_sense_pin,
   input wire logic sinks_active,
   input wire boost_ctrl_pkg::sink_in_t sink_output,
   // Feedback comparators, thresholds supplied from target_code
   input wire logic fb_above_low_ovp,
   input wire logic fb_above_high_ovp,
   input wire logic fb_below_uvp,
   // Register port
   input wire boost_ctrl_pkg::bus_req_t bus,
   output logic [31:0] rdata,
   // Outputs
   output logic gate_drive,
   output logic [11:0] target_code,
   output logic irq
);
   import boost_ctrl_pkg::*;

   localparam int PER_W = 12;

   // ==========================================================
   // Helpers
   // ==========================================================
   // Code to period in cycles of 5 ns
   function automatic logic [PER_W-1:0] period_of(input logic [2:0] code);
      case (code)
         3'd0: period_of = 12'd500;   // 400 kHz
         3'd1: period_of = 12'd1000;  // 200 kHz
         3'd2: period_of = 12'd660;   // 303 kHz
         3'd3: period_of = 12'd2000;  // 100 kHz
         3'd4: period_of = 12'd400;   // 500 kHz
         3'd5: period_of = 12'd110;   // 1818 kHz
         3'd6: period_of = 12'd100;   // 2000 kHz
         default: period_of = 12'd90; // 2222 kHz
      endcase
   endfunction

   function automatic logic [5:0] strings_of(input logic [2:0] cfg);
      case (cfg)
         3'd0: strings_of = 6'b11_1111;
         3'd1: strings_of = 6'b01_1111;
         3'd2: strings_of = 6'b00_1111;
         3'd3: strings_of = 6'b00_0111;
         3'd4: strings_of = 6'b00_0011;
         3'd5: strings_of = 6'b11_1111;
         3'd6: strings_of = 6'b11_1111;
         default: strings_of = 6'b11_1111;
      endcase
   endfunction

   localparam logic [11:0] TARGET_INIT =
      12'((32'(`TARGET_MAX) * `TARGET_INIT_PCT) / 100);
   localparam logic [7:0] MIN_OFF_LO = 8'(`NS_TO_CYC_UP(`MIN_OFF_LO_NS));
   localparam logic [7:0] MIN_ON_LO = 8'(`NS_TO_CYC_UP(`MIN_ON_LO_NS));
   localparam logic [7:0] MIN_OFF_HI = 8'(`NS_TO_CYC_UP(`MIN_OFF_HI_NS));
   localparam logic [7:0] MIN_ON_HI = 8'(`NS_TO_CYC_UP(`MIN_ON_HI_NS));

   // ==========================================================
   // State
   // ==========================================================
   typedef struct packed {
      logic [1:0] en_s;
      logic [1:0] cs_s;
      logic [1:0] ovl_s;
      logic [1:0] ovh_s;
      logic [1:0] uv_s;
      logic [1:0] act_s;
      logic [5:0] fsel_s;
      logic [5:0] scfg_s;
      logic [11:0] low_s;
      logic en_d;
      mode_t mode;
      logic [2:0] freq_code;
      logic [5:0] strings;
      logic [PER_W-1:0] period;
      logic [PER_W-1:0] cnt;
      logic gate;
      logic limited;
      logic [11:0] target;
      logic [15:0] step_cnt;
      logic [31:0] uv_cnt;
      logic [31:0] rec_cnt;
      logic [2:0] status;
      logic [2:0] irq_en;
      logic run_en;
      logic [31:0] rdata;
      logic irq;
   } state_t;

   state_t st_reg;
   state_t st_next;

   logic [5:0] used;
   logic [7:0] min_on;
   logic [7:0] min_off;
   logic [2:0] ev;
   logic [2:0] clr;
   logic hi_band;

   always_comb begin
      st_next = st_reg;
      // Two-flop synchronisers; only the second stage is read
      st_next.en_s = {st_reg.en_s[0], enable_pin};
      st_next.cs_s = {st_reg.cs_s[0], current_sense_pin};
      st_next.ovl_s = {st_reg.ovl_s[0], fb_above_low_ovp};
      st_next.ovh_s = {st_reg.ovh_s[0], fb_above_high_ovp};
      st_next.uv_s = {st_reg.uv_s[0], fb_below_uvp};
      st_next.act_s = {st_reg.act_s[0], sinks_active};
      st_next.fsel_s = {st_reg.fsel_s[2:0], boost_freq_select_pin};
      st_next.scfg_s = {st_reg.scfg_s[2:0], string_config_pin};
      st_next.low_s = {st_reg.low_s[5:0], sink_output.sink_low};
      st_next.en_d = st_reg.en_s[1];

      hi_band = st_reg.freq_code inside {3'd5, 3'd6, 3'd7};
      min_on = hi_band ? MIN_ON_HI : MIN_ON_LO;
      min_off = hi_band ? MIN_OFF_HI : MIN_OFF_LO;
      used = st_reg.strings & ~sink_output.sink_fault;
      ev = 3'b000;
      clr = 3'b000;

      // ======================================================
      // Register port
      // ======================================================
      st_next.rdata = 32'h0000_0000;
      if (bus.rd) begin
         case (bus.addr)
            `REG_STATUS: st_next.rdata = {29'h0, st_reg.status};
            `REG_IRQ_EN: st_next.rdata = {29'h0, st_reg.irq_en};
            `REG_CTRL: st_next.rdata = {31'h0, st_reg.run_en};
            `REG_TARGET: st_next.rdata = {20'h0, st_reg.target};
            `REG_FREQ: st_next.rdata = {20'h0, st_reg.mode, 5'h0, st_reg.freq_code};
            default: st_next.rdata = 32'h0000_0000;
         endcase
      end
      if (bus.wr) begin
         case (bus.addr)
            `REG_CLEAR: clr = bus.wdata[2:0];
            `REG_IRQ_EN: st_next.irq_en = bus.wdata[2:0];
            `REG_CTRL: st_next.run_en = bus.wdata[0];
            default: ;
         endcase
      end
      if (st_reg.en_d && !st_reg.en_s[1]) begin
         clr = 3'b111;
      end

      // ======================================================
      // Mode sequencing
      // ======================================================
      case (st_reg.mode)
         ST_IDLE: begin
            if (st_reg.en_s[1] && st_reg.run_en) begin
               st_next.freq_code = st_reg.fsel_s[5:3];
               st_next.period = period_of(st_reg.fsel_s[5:3]);
               st_next.strings = strings_of(st_reg.scfg_s[5:3]);
               st_next.target = TARGET_INIT;
               st_next.mode = ST_START;
            end
         end
         ST_START: begin
            if (st_reg.act_s[1]) begin
               st_next.mode = ST_RUN;
            end
         end
         ST_RUN: begin
            // Sink levels use delayed copies to settle past the sync
            st_next.step_cnt = st_reg.step_cnt + 16'd1;
            if (st_reg.step_cnt == 16'(STEP_CYC - 1)) begin
               st_next.step_cnt = 16'd0;
               if (|(st_reg.low_s[11:6] & used)) begin
                  if (st_reg.target != `TARGET_MAX) begin
                     st_next.target = st_reg.target + 12'd1;
                  end
               end else if (used != 6'd0 && st_reg.target != 12'd0) begin
                  st_next.target = st_reg.target - 12'd1;
               end
            end
         end
         ST_RECOVER: begin
            st_next.rec_cnt = st_reg.rec_cnt + 32'd1;
            if (st_reg.rec_cnt == 32'(REC_CYC - 1)) begin
               st_next.rec_cnt = 32'd0;
               st_next.target = TARGET_INIT;
               st_next.mode = ST_START;
            end
         end
         default: st_next.mode = ST_IDLE;
      endcase

      // ======================================================
      // Fault detection, thresholds follow target_code outside
      // ======================================================
      if (st_reg.mode == ST_RUN || st_reg.mode == ST_START) begin
         if (st_reg.ovl_s[1]) begin
            ev[`ST_LOWER_OVERVOLT_LEVEL] = 1'b1;
         end
         if (st_reg.ovh_s[1]) begin
            ev[`ST_UPPER_OVERVOLT_LEVEL] = 1'b1;
            st_next.mode = ST_RECOVER;
         end
         if (st_reg.uv_s[1]) begin
            st_next.uv_cnt = st_reg.uv_cnt + 32'd1;
            if (st_reg.uv_cnt == 32'(UV_CYC - 1)) begin
               ev[`ST_OCP] = 1'b1;
               st_next.mode = ST_RECOVER;
            end
         end else begin
            st_next.uv_cnt = 32'd0;
         end
      end else begin
         st_next.uv_cnt = 32'd0;
      end
      if (!st_reg.en_s[1] || !st_reg.run_en) begin
         st_next.mode = ST_IDLE;
      end
      // Set wins over clear
      st_next.status = (st_reg.status & ~clr) | ev;
      st_next.irq = |(st_next.status & st_reg.irq_en);

      // ======================================================
      // Switching cycle
      // ======================================================
      st_next.cnt = st_reg.cnt + 12'd1;
      if (st_reg.cnt >= st_reg.period - 12'd1) begin
         st_next.cnt = 12'd0;
         st_next.limited = 1'b0;
      end
      if (st_reg.gate && st_reg.cs_s[1] && st_reg.cnt >= 12'(min_on)) begin
         st_next.limited = 1'b1;
      end
      // Gate high from period start until limit or minimum off window
      st_next.gate = (st_reg.mode == ST_RUN || st_reg.mode == ST_START)
         && !st_reg.ovl_s[1] && !st_next.limited
         && (st_reg.gate || st_next.cnt == 12'd0)
         && st_next.cnt < st_reg.period - 12'(min_off);
      if (st_reg.gate && !st_next.gate && st_reg.cnt < 12'(min_on)
            && !st_reg.ovl_s[1] && st_reg.mode == ST_RUN) begin
         st_next.gate = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st_reg <= '0;
         st_reg.mode <= ST_IDLE;
         st_reg.period <= 12'd500;
         st_reg.target <= 12'h0000;
         st_reg.run_en <= 1'(`CTRL_RESET_VAL);
      end else begin
         st_reg <= st_next;
      end
   end

   assign rdata = st_reg.rdata;
   assign gate_drive = st_reg.gate;
   assign target_code = st_reg.target;
   assign irq = st_reg.irq;

   // ==========================================================
   // Checks
   // ==========================================================
   limit_no_flag_a: assert property (@(posedge clk) disable iff (reset)
      st_reg.limited && !st_reg.ovh_s[1] && !st_reg.uv_s[1] && !st_reg.ovl_s[1]
      |=> (st_reg.status & ~$past(st_reg.status)) == 3'b000)
      else $error("current limit set a flag");
   limit_off_a: assert property (@(posedge clk) disable iff (reset)
      st_reg.limited |-> !st_reg.gate)
      else $error("gate on while limited");
   ovl_stop_a: assert property (@(posedge clk) disable iff (reset)
      st_reg.ovl_s[1] && st_reg.mode == ST_RUN |=> !st_reg.gate ##0 st_reg.status[0])
      else $error("low ovp did not stop gate");
   ovh_recover_a: assert property (@(posedge clk) disable iff (reset)
      st_reg.ovh_s[1] && st_reg.mode == ST_RUN && st_reg.en_s[1] && st_reg.run_en
      |=> st_reg.mode == ST_RECOVER && st_reg.status[1])
      else $error("high ovp not handled");
   recover_off_a: assert property (@(posedge clk) disable iff (reset)
      st_reg.mode == ST_RECOVER |=> !st_reg.gate)
      else $error("switching in recovery");
   start_target_a: assert property (@(posedge clk) disable iff (reset)
      st_reg.mode == ST_START && $past(st_reg.mode) != ST_START
      |-> st_reg.target == TARGET_INIT)
      else $error("start target wrong");
   raise_step_a: assert property (@(posedge clk) disable iff (reset)
      st_reg.mode == ST_RUN && st_next.mode == ST_RUN && st_reg.step_cnt == 16'(STEP_CYC - 1)
      && |(st_reg.low_s[11:6] & used) && st_reg.target != `TARGET_MAX
      |=> st_reg.target == $past(st_reg.target) + 12'd1)
      else $error("target not raised");
   clear_flag_a: assert property (@(posedge clk) disable iff (reset)
      bus.wr && bus.addr == `REG_CLEAR && bus.wdata[0] && ev[0] == 1'b0
      |=> !st_reg.status[0])
      else $error("status clear failed");
endmodule

//--- verif/power_stage_model.sv
`timescale 1ns/10ps

module power_stage_model (
   // Clock
   input wire logic clk,
   // Gate and ramp setting
   input wire logic gate_drive,
   input wire logic [7:0] on_limit,
   // Sense comparator
   output logic current_sense_pin
);
   logic [7:0] on_cnt;

   initial on_cnt = 8'h00;

   // Inductor current ramps only while the FET conducts
   always @(posedge clk) begin
      on_cnt <= gate_drive ? on_cnt + 8'h01 : 8'h00;
   end

   // Zero limit trips at once: the harshest case for minimum on time
   assign current_sense_pin = gate_drive && (on_cnt >= on_limit);
endmodule

//--- verif/testbench.sv
`timescale 1ns/10ps
`include "boost_ctrl_defs.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
   $display("[FAIL] %0t got %0h expected %0h", $time, g, e); end end

module testbench;
   import boost_ctrl_pkg::*;
   localparam int UV = 200;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic enable_pin = 1'b0;
   logic [2:0] boost_freq_select_pin = 3'h0;
   logic [2:0] string_config_pin = 3'h4;
   logic current_sense_pin;
   logic sinks_active = 1'b0;
   sink_in_t sink_output = '0;
   logic fb_above_low_ovp = 1'b0;
   logic fb_above_high_ovp = 1'b0;
   logic fb_below_uvp = 1'b0;
   bus_req_t bus = '0;
   logic [31:0] rdata;
   logic gate_drive;
   logic [11:0] target_code;
   logic irq;
   logic [7:0] on_limit = 8'h00;
   int num_errors = 0;
   int tests_run = 0;
   int hi, per, cnt;
   int ptab[8] = '{500, 1000, 660, 2000, 400, 110, 100, 90};
   logic [11:0] t0;
   logic [31:0] d;

   always #2.5 clk = ~clk;

   boost_ctrl #(.UV_CYC(UV), .REC_CYC(50), .STEP_CYC(8)) dut (.clk, .reset, .enable_pin,
      .boost_freq_select_pin, .string_config_pin, .current_sense_pin, .sinks_active,
      .sink_output, .fb_above_low_ovp, .fb_above_high_ovp, .fb_below_uvp, .bus, .rdata,
      .gate_drive, .target_code, .irq);

   power_stage_model stage (.clk, .gate_drive, .on_limit, .current_sense_pin);

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk);
      bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk);
      bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1 v = rdata;
   endtask

   task automatic check_reg(input logic [3:0] a, input logic [31:0] e);
      logic [31:0] v;
      rd(a, v);
      `CHK(v, e)
   endtask

   task automatic wait_gate(input logic lvl);
      int n;
      n = 0;
      while (gate_drive !== lvl) begin
         @(posedge clk);
         #1 n++;
         if (n > 5000) begin
            num_errors++;
            $display("[FAIL] %0t gate wait ran out", $time);
            print_verdict();
         end
      end
   endtask

   task automatic wait_target(input logic [11:0] e);
      int n;
      n = 0;
      while (target_code !== e && n < 40000) begin
         @(posedge clk);
         #1 n++;
      end
      `CHK(target_code, e)
      if (target_code !== e) print_verdict();
   endtask

   // Period and high time of one whole gate cycle
   task automatic measure();
      wait_gate(1'b0);
      wait_gate(1'b1);
      hi = 0;
      per = 0;
      while (gate_drive === 1'b1 && per < 5000) begin
         @(posedge clk);
         #1 hi++;
         per++;
      end
      while (gate_drive !== 1'b1 && per < 5000) begin
         @(posedge clk);
         #1 per++;
      end
      if (per >= 5000) begin
         num_errors++;
         $display("[FAIL] %0t period count ran out", $time);
         print_verdict();
      end
   endtask

   task automatic count_high(input int n);
      cnt = 0;
      repeat (n) begin
         @(posedge clk);
         #1 cnt += (gate_drive !== 1'b0);
      end
   endtask

   task automatic restart();
      enable_pin <= 1'b0;
      repeat (8) @(posedge clk);
      enable_pin <= 1'b1;
   endtask

   initial begin
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      check_reg(`REG_CTRL, `CTRL_RESET_VAL);
      wr(`REG_STATUS, 32'h0000_0007);
      check_reg(`REG_STATUS, 32'h0000_0000);
      check_reg(4'hF, 32'h0000_0000);
      // Every frequency code, with the current limit tripping at once
      for (int c = 0; c < 8; c++) begin
         boost_freq_select_pin <= c[2:0];
         restart();
         measure();
         measure();
         `CHK(per inside {[ptab[c] - 1:ptab[c] + 1]}, 1'b1)
         `CHK(hi >= (c < 5 ? 30 : 22), 1'b1)
         `CHK(per - hi >= (c < 5 ? 30 : 8), 1'b1)
         rd(`REG_FREQ, d);
         `CHK(d[2:0], c[2:0])
         `CHK(d[11:8], ST_START)
      end
      check_reg(`REG_STATUS, 32'h0000_0000);
      on_limit <= 8'h30;
      wait_target(12'hE13);
      sink_output.sink_low <= 6'h3F;
      repeat (200) @(posedge clk);
      `CHK(target_code, 12'hE13)
      // Unused strings low must not hold the target up
      sink_output.sink_low <= 6'h3C;
      sinks_active <= 1'b1;
      repeat (200) @(posedge clk);
      `CHK(target_code < 12'hE13, 1'b1)
      t0 = target_code;
      sink_output <= '{sink_low: 6'h01, sink_fault: 6'h01};
      repeat (200) @(posedge clk);
      `CHK(target_code < t0, 1'b1)
      t0 = target_code;
      sink_output <= '{sink_low: 6'h02, sink_fault: 6'h00};
      repeat (200) @(posedge clk);
      `CHK(target_code > t0, 1'b1)
      // Low over-voltage: switching pauses, sinks stay on
      wr(`REG_IRQ_EN, 32'h0000_0007);
      fb_above_low_ovp <= 1'b1;
      repeat (10) @(posedge clk);
      count_high(300);
      `CHK(cnt, 0)
      check_reg(`REG_STATUS, 32'h0000_0001);
      `CHK(irq, 1'b1)
      fb_above_low_ovp <= 1'b0;
      wait_gate(1'b1);
      wr(`REG_CLEAR, 32'h0000_0001);
      check_reg(`REG_STATUS, 32'h0000_0000);
      `CHK(irq, 1'b0)
      // High over-voltage: recovery, then restart from the initial target
      sinks_active <= 1'b0;
      fb_above_high_ovp <= 1'b1;
      repeat (10) @(posedge clk);
      fb_above_high_ovp <= 1'b0;
      count_high(30);
      `CHK(cnt, 0)
      check_reg(`REG_STATUS, 32'h0000_0002);
      wait_target(12'hE13);
      wait_gate(1'b1);
      check_reg(`REG_TARGET, 32'h0000_0E13);
      // Run enable off: switching must stay silent
      wr(`REG_CTRL, 32'h0000_0000);
      repeat (2) @(posedge clk);
      count_high(200);
      `CHK(cnt, 0)
      check_reg(`REG_CTRL, 32'h0000_0000);
      wr(`REG_CTRL, 32'h0000_0001);
      wait_gate(1'b1);
      check_reg(`REG_TARGET, 32'h0000_0E13);
      restart();
      repeat (8) @(posedge clk);
      check_reg(`REG_STATUS, 32'h0000_0000);
      // Short dip recovers in time, long dip does not
      wr(`REG_IRQ_EN, 32'h0000_0000);
      fb_below_uvp <= 1'b1;
      repeat (UV / 2) @(posedge clk);
      fb_below_uvp <= 1'b0;
      repeat (UV) @(posedge clk);
      check_reg(`REG_STATUS, 32'h0000_0000);
      fb_below_uvp <= 1'b1;
      repeat (UV / 2) @(posedge clk);
      check_reg(`REG_STATUS, 32'h0000_0000);
      repeat (UV) @(posedge clk);
      fb_below_uvp <= 1'b0;
      check_reg(`REG_STATUS, 32'h0000_0004);
      `CHK(irq, 1'b0)
      wr(`REG_IRQ_EN, 32'h0000_0004);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b1)
      // Mid-run reset drops latched state and outputs
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      `CHK(target_code, 12'h000)
      `CHK(irq, 1'b0)
      reset <= 1'b0;
      check_reg(`REG_STATUS, 32'h0000_0000);
      check_reg(`REG_CTRL, `CTRL_RESET_VAL);
      print_verdict();
   end
endmodule
